/* verilog/fsc_pkg.sv */
// Shared constants, types and helpers of the file-system command controller.
// Assumes a drive with 512-byte sectors behind a request/busy storage controller.
package fsc_pkg;

  // User command codes.
  localparam logic [1:0] CMD_FORMAT = 2'h0;
  localparam logic [1:0] CMD_SHUTDOWN = 2'h1;
  localparam logic [1:0] CMD_WRITE = 2'h2;

  // Storage controller command codes.
  localparam logic [2:0] NV_IDENTIFY = 3'h0;
  localparam logic [2:0] NV_WRITE = 3'h2;
  localparam logic [2:0] NV_SHUTDOWN = 3'h4;

  // Wishbone register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DIR_CAP = 8'h08;
  localparam logic [7:0] REG_TOTAL_CAP = 8'h0c;
  localparam logic [7:0] REG_FILE_SIZE = 8'h10;
  localparam logic [7:0] REG_FILE_COUNT = 8'h14;

  // Control register field and reset value.
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;

  // Status register field positions.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DEAD_BIT = 1;
  localparam int ST_BAD_BIT = 2;
  localparam int ST_STATE_LSB = 4;

  // Transmit FIFO burst: 32 beats of 128 bits, level bits 15..5 hold whole bursts.
  localparam int BURST_BEATS = 32;
  localparam int LEVEL_LSB = 5;

  // Layout on the drive, in sectors.
  localparam logic [8:0] DIR_LAST = 9'h1ff;
  localparam logic [47:0] INFO_LBA = 48'h0000_0000_0800;
  localparam logic [47:0] DIR_LBA = 48'h0000_0000_1000;
  localparam logic [47:0] DATA_LBA = 48'h0000_0001_0000;
  localparam int BASE_SHIFT = 16;
  localparam int DIRS_SHIFT = 9;

  typedef enum logic [3:0] {
    ST_ID_REQ, ST_ID_WAIT, ST_IDLE, ST_FMT_INFO, ST_FMT_IWAIT, ST_FMT_DIR,
    ST_FMT_DWAIT, ST_SHUT_WAIT, ST_DEAD, ST_WR_LOC, ST_WR_FILE, ST_WR_DATA, ST_WR_DONE
  } fsc_state_t;

  // Sectors per file as a power of two: 32 MB grows fourfold per size code.
  function automatic logic [5:0] fsc_sect_shift(input logic [2:0] code);
    return 6'(BASE_SHIFT) + {2'h0, code, 1'b0};
  endfunction

endpackage

/* verilog/fsc_nvme_seq.sv */
// Issues one request to the storage controller and reports its completion.
// Assumes the controller raises busy after a request and drops it when done.
`timescale 1ns/100ps
`default_nettype none
module fsc_nvme_seq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [2:0] cmd_i,
  input wire logic [47:0] addr_i,
  input wire logic [47:0] len_i,
  input wire logic nvme_busy_i,
  output logic nvme_req_o,
  output logic [2:0] nvme_cmd_o,
  output logic [47:0] nvme_addr_o,
  output logic [47:0] nvme_len_o,
  output logic done_o
);
  logic wait_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nvme_req_o <= 1'b0;
      nvme_cmd_o <= 3'h0;
      nvme_addr_o <= 48'h0;
      nvme_len_o <= 48'h0;
      wait_ff <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (go_i) begin
        nvme_req_o <= 1'b1;
        nvme_cmd_o <= cmd_i;
        nvme_addr_o <= addr_i;
        nvme_len_o <= len_i;
      end else if (nvme_req_o && nvme_busy_i) begin
        nvme_req_o <= 1'b0;
        wait_ff <= 1'b1;
      end else if (wait_ff && !nvme_busy_i) begin
        wait_ff <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/fsc_burst_rd.sv */
// Moves one 512-byte burst from the transmit FIFO to the storage data port.
// Assumes FIFO read data is valid in the cycle after each pop.
`timescale 1ns/100ps
`default_nettype none
module fsc_burst_rd #(
  parameter int BEATS = fsc_pkg::BURST_BEATS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [15:0] level_i,
  input wire logic [127:0] dout_i,
  output logic pop_o,
  output logic [127:0] wdata_o,
  output logic wvalid_o,
  output logic ready_o
);
  logic wait_ff;
  logic pop_d_ff;
  logic [5:0] beat_ff;
  wire have_burst = |level_i[15:fsc_pkg::LEVEL_LSB];
  wire last_beat = beat_ff == 6'(BEATS - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_ff <= 1'b0;
      pop_o <= 1'b0;
      pop_d_ff <= 1'b0;
      beat_ff <= 6'h0;
      ready_o <= 1'b1;
      wvalid_o <= 1'b0;
      wdata_o <= 128'h0;
    end else begin
      pop_d_ff <= pop_o;
      wvalid_o <= pop_d_ff;
      if (pop_d_ff) begin
        wdata_o <= dout_i;
      end
      if (go_i && ready_o) begin
        ready_o <= 1'b0;
        wait_ff <= 1'b1;
      end else if (wait_ff && have_burst) begin
        wait_ff <= 1'b0;
        pop_o <= 1'b1;
        beat_ff <= 6'h0;
      end else if (pop_o) begin
        beat_ff <= beat_ff + 6'h1;
        pop_o <= !last_beat;
      end else if (!ready_o && !wait_ff && !pop_d_ff) begin
        ready_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/fsc_ctrl.sv */
// Command controller of a file-system recorder in front of a storage controller.
// Assumes a classic Wishbone master and user logic that keeps the request handshake.
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module fsc_ctrl #(
  parameter int DATE_W = 32,
  parameter int TIME_W = 32,
  parameter int FNUM_W = 27,
  parameter int FPD_W = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cmd_request_i,
  input wire logic [1:0] cmd_code_i,
  input wire logic [DATE_W-1:0] create_date_ymd_i,
  input wire logic [TIME_W-1:0] create_time_hms_i,
  input wire logic [2:0] file_size_sel_i,
  input wire logic [FNUM_W-1:0] first_file_number_i,
  input wire logic [FNUM_W-1:0] file_count_req_i,
  output logic cmd_busy_o,
  output logic [FPD_W-1:0] files_per_directory_o,
  output logic [FNUM_W-1:0] total_file_capacity_o,
  output logic [2:0] current_file_size_o,
  output logic [FNUM_W-1:0] stored_file_count_o,
  input wire logic [15:0] tx_fifo_level_i,
  output logic tx_fifo_pop_o,
  input wire logic [127:0] tx_fifo_dout_i,
  output logic nvme_req_o,
  output logic [2:0] nvme_cmd_o,
  output logic [47:0] nvme_addr_o,
  output logic [47:0] nvme_len_o,
  input wire logic nvme_busy_i,
  input wire logic [47:0] nvme_capacity_i,
  output logic [127:0] nvme_wdata_o,
  output logic nvme_wvalid_o,
  output logic [FNUM_W-1:0] meta_index_o,
  output logic [FNUM_W-1:0] meta_dir_o,
  output logic [DATE_W-1:0] meta_date_o,
  output logic [TIME_W-1:0] meta_time_o
);
  fsc_pkg::fsc_state_t state_ff, nxt_state;
  logic busy_ff, nxt_busy;
  logic [1:0] code_ff, nxt_code;
  logic [DATE_W-1:0] date_ff, nxt_date;
  logic [TIME_W-1:0] time_ff, nxt_time;
  logic [2:0] fsel_ff, nxt_fsel;
  logic [FNUM_W-1:0] first_ff, nxt_first;
  logic [FNUM_W-1:0] cnt_ff, nxt_cnt;
  logic [FPD_W-1:0] fpd_ff, nxt_fpd;
  logic [FNUM_W-1:0] tfc_ff, nxt_tfc;
  logic [2:0] fsize_ff, nxt_fsize;
  logic [FNUM_W-1:0] fcount_ff, nxt_fcount;
  logic [47:0] cap_ff, nxt_cap;
  logic [FNUM_W-1:0] idx_ff, nxt_idx;
  logic [FNUM_W-1:0] left_ff, nxt_left;
  logic [FNUM_W-1:0] slot_ff, nxt_slot;
  logic [FNUM_W-1:0] dir_ff, nxt_dir;
  logic [31:0] sect_ff, nxt_sect;
  logic seen_ff, nxt_seen;
  logic bad_ff, nxt_bad;
  logic en_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [FNUM_W-1:0] mindex_ff, nxt_mindex;
  logic [FNUM_W-1:0] mdir_ff, nxt_mdir;
  logic seq_go;
  logic [2:0] seq_cmd;
  logic [47:0] seq_addr;
  logic [47:0] seq_len;
  logic seq_done;
  logic burst_go;
  logic burst_ready;

  // Size codes: the format uses the request's code taken at accept, the write the code of the last format.
  wire [5:0] shift_cap = fsc_pkg::fsc_sect_shift(fsel_ff);
  wire [5:0] shift_wr = fsc_pkg::fsc_sect_shift(fsize_ff);
  wire [47:0] data_sectors = cap_ff - fsc_pkg::DATA_LBA;
  wire [47:0] fpd_raw = nvme_capacity_i >> (fsc_pkg::BASE_SHIFT + fsc_pkg::DIRS_SHIFT);
  wire [FPD_W-1:0] fpd_new = (fpd_raw == 48'h0) ? FPD_W'(1) :
                             (|fpd_raw[47:FPD_W]) ? {FPD_W{1'b1}} : fpd_raw[FPD_W-1:0];
  wire [FNUM_W-1:0] fpd_ext = FNUM_W'(fpd_ff);
  wire [FNUM_W:0] wr_end = {1'b0, first_ff} + {1'b0, cnt_ff};
  wire accept = cmd_request_i && en_ff && !busy_ff;
  wire last_in_dir = (slot_ff + FNUM_W'(1)) == fpd_ext;
  wire file_over = (sect_ff == 32'h0) && burst_ready && (seen_ff || seq_done);

  // Wishbone decode; reads of unmapped words return zero.
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire [7:0] wb_word = {wb_adr_i[7:2], 2'h0};
  wire wr_ctrl = ack_ff && wb_cyc_i && wb_we_i && wb_sel_i[0] && (wb_word == fsc_pkg::REG_CTRL);
  wire [31:0] status_word = (32'(busy_ff) << fsc_pkg::ST_BUSY_BIT) |
                            (32'(state_ff == fsc_pkg::ST_DEAD) << fsc_pkg::ST_DEAD_BIT) |
                            (32'(bad_ff) << fsc_pkg::ST_BAD_BIT) |
                            (32'(state_ff) << fsc_pkg::ST_STATE_LSB);
  wire [31:0] rd_mux = (wb_word == fsc_pkg::REG_CTRL) ? 32'(en_ff) :
                       (wb_word == fsc_pkg::REG_STATUS) ? status_word :
                       (wb_word == fsc_pkg::REG_DIR_CAP) ? 32'(fpd_ff) :
                       (wb_word == fsc_pkg::REG_TOTAL_CAP) ? 32'(tfc_ff) :
                       (wb_word == fsc_pkg::REG_FILE_SIZE) ? 32'(fsize_ff) :
                       (wb_word == fsc_pkg::REG_FILE_COUNT) ? 32'(fcount_ff) : 32'h0;

  always_comb begin
    nxt_state = state_ff;
    nxt_busy = busy_ff;
    nxt_code = code_ff;
    nxt_date = date_ff;
    nxt_time = time_ff;
    nxt_fsel = fsel_ff;
    nxt_first = first_ff;
    nxt_cnt = cnt_ff;
    nxt_fpd = fpd_ff;
    nxt_tfc = tfc_ff;
    nxt_fsize = fsize_ff;
    nxt_fcount = fcount_ff;
    nxt_cap = cap_ff;
    nxt_idx = idx_ff;
    nxt_left = left_ff;
    nxt_slot = slot_ff;
    nxt_dir = dir_ff;
    nxt_sect = sect_ff;
    nxt_seen = seen_ff || seq_done;
    nxt_bad = bad_ff;
    nxt_mindex = mindex_ff;
    nxt_mdir = mdir_ff;
    seq_go = 1'b0;
    seq_cmd = fsc_pkg::NV_WRITE;
    seq_addr = 48'h0;
    seq_len = 48'h1;
    burst_go = 1'b0;
    case (state_ff)
      fsc_pkg::ST_ID_REQ: begin
        seq_go = 1'b1;
        seq_cmd = fsc_pkg::NV_IDENTIFY;
        nxt_state = fsc_pkg::ST_ID_WAIT;
      end
      fsc_pkg::ST_ID_WAIT: begin
        if (seq_done) begin
          nxt_cap = nvme_capacity_i;
          nxt_fpd = fpd_new;
          nxt_busy = 1'b0;
          nxt_state = fsc_pkg::ST_IDLE;
        end
      end
      fsc_pkg::ST_IDLE: begin
        if (accept) begin
          nxt_code = cmd_code_i;
          nxt_date = create_date_ymd_i;
          nxt_time = create_time_hms_i;
          nxt_fsel = file_size_sel_i;
          nxt_first = first_file_number_i;
          nxt_cnt = file_count_req_i;
          if (cmd_code_i == fsc_pkg::CMD_FORMAT) begin
            nxt_busy = 1'b1;
            nxt_state = fsc_pkg::ST_FMT_INFO;
          end else if (cmd_code_i == fsc_pkg::CMD_SHUTDOWN) begin
            nxt_busy = 1'b1;
            seq_go = 1'b1;
            seq_cmd = fsc_pkg::NV_SHUTDOWN;
            nxt_state = fsc_pkg::ST_SHUT_WAIT;
          end else if (cmd_code_i == fsc_pkg::CMD_WRITE) begin
            nxt_busy = 1'b1;
            nxt_bad = first_file_number_i > fcount_ff;
            nxt_idx = first_file_number_i;
            nxt_slot = first_file_number_i;
            nxt_left = file_count_req_i;
            nxt_dir = '0;
            nxt_state = fsc_pkg::ST_WR_LOC;
          end
        end
      end
      fsc_pkg::ST_FMT_INFO: begin
        seq_go = 1'b1;
        seq_addr = fsc_pkg::INFO_LBA;
        nxt_idx = '0;
        nxt_state = fsc_pkg::ST_FMT_IWAIT;
      end
      fsc_pkg::ST_FMT_IWAIT: begin
        if (seq_done) begin
          nxt_state = fsc_pkg::ST_FMT_DIR;
        end
      end
      fsc_pkg::ST_FMT_DIR: begin
        seq_go = 1'b1;
        seq_addr = fsc_pkg::DIR_LBA + 48'(idx_ff);
        nxt_mindex = idx_ff;
        nxt_mdir = idx_ff;
        nxt_state = fsc_pkg::ST_FMT_DWAIT;
      end
      fsc_pkg::ST_FMT_DWAIT: begin
        if (seq_done && idx_ff == FNUM_W'(fsc_pkg::DIR_LAST)) begin
          nxt_tfc = FNUM_W'(data_sectors >> shift_cap);
          nxt_fsize = fsel_ff;
          nxt_fcount = '0;
          nxt_busy = 1'b0;
          nxt_state = fsc_pkg::ST_IDLE;
        end else if (seq_done) begin
          nxt_idx = idx_ff + FNUM_W'(1);
          nxt_state = fsc_pkg::ST_FMT_DIR;
        end
      end
      fsc_pkg::ST_SHUT_WAIT: begin
        if (seq_done) begin
          nxt_busy = 1'b0;
          nxt_state = fsc_pkg::ST_DEAD;
        end
      end
      fsc_pkg::ST_DEAD: begin
        nxt_state = fsc_pkg::ST_DEAD;
      end
      fsc_pkg::ST_WR_LOC: begin
        if (slot_ff >= fpd_ext) begin
          nxt_slot = slot_ff - fpd_ext;
          nxt_dir = dir_ff + FNUM_W'(1);
        end else if (left_ff == '0) begin
          nxt_state = fsc_pkg::ST_WR_DONE;
        end else begin
          nxt_state = fsc_pkg::ST_WR_FILE;
        end
      end
      fsc_pkg::ST_WR_FILE: begin
        seq_go = 1'b1;
        seq_addr = fsc_pkg::DATA_LBA + (48'(idx_ff) << shift_wr);
        seq_len = 48'h1 << shift_wr;
        nxt_sect = 32'h1 << shift_wr;
        nxt_seen = 1'b0;
        nxt_mindex = idx_ff;
        nxt_mdir = dir_ff;
        nxt_state = fsc_pkg::ST_WR_DATA;
      end
      fsc_pkg::ST_WR_DATA: begin
        if (sect_ff != 32'h0 && burst_ready) begin
          burst_go = 1'b1;
          nxt_sect = sect_ff - 32'h1;
        end else if (file_over) begin
          nxt_idx = idx_ff + FNUM_W'(1);
          nxt_left = left_ff - FNUM_W'(1);
          nxt_slot = last_in_dir ? '0 : slot_ff + FNUM_W'(1);
          nxt_dir = last_in_dir ? dir_ff + FNUM_W'(1) : dir_ff;
          nxt_state = (left_ff == FNUM_W'(1)) ? fsc_pkg::ST_WR_DONE : fsc_pkg::ST_WR_FILE;
        end
      end
      fsc_pkg::ST_WR_DONE: begin
        if (!bad_ff && wr_end[FNUM_W-1:0] > fcount_ff) begin
          nxt_fcount = wr_end[FNUM_W-1:0];
        end
        nxt_busy = 1'b0;
        nxt_state = fsc_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = fsc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= fsc_pkg::ST_ID_REQ;
      busy_ff <= 1'b1;
      code_ff <= 2'h0;
      date_ff <= '0;
      time_ff <= '0;
      fsel_ff <= 3'h0;
      first_ff <= '0;
      cnt_ff <= '0;
      fpd_ff <= '0;
      tfc_ff <= '0;
      fsize_ff <= 3'h0;
      fcount_ff <= '0;
      cap_ff <= 48'h0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= nxt_busy;
      code_ff <= nxt_code;
      date_ff <= nxt_date;
      time_ff <= nxt_time;
      fsel_ff <= nxt_fsel;
      first_ff <= nxt_first;
      cnt_ff <= nxt_cnt;
      fpd_ff <= nxt_fpd;
      tfc_ff <= nxt_tfc;
      fsize_ff <= nxt_fsize;
      fcount_ff <= nxt_fcount;
      cap_ff <= nxt_cap;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_ff <= '0;
      left_ff <= '0;
      slot_ff <= '0;
      dir_ff <= '0;
      sect_ff <= 32'h0;
      seen_ff <= 1'b0;
      bad_ff <= 1'b0;
      mindex_ff <= '0;
      mdir_ff <= '0;
    end else begin
      idx_ff <= nxt_idx;
      left_ff <= nxt_left;
      slot_ff <= nxt_slot;
      dir_ff <= nxt_dir;
      sect_ff <= nxt_sect;
      seen_ff <= nxt_seen;
      bad_ff <= nxt_bad;
      mindex_ff <= nxt_mindex;
      mdir_ff <= nxt_mdir;
    end
  end

  // Ack comes one cycle after the strobe and drops the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff <= fsc_pkg::CTRL_EN_RST;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff <= wb_req;
      if (wb_req) begin
        rdat_ff <= wb_we_i ? 32'h0 : rd_mux;
      end
      if (wr_ctrl) begin
        en_ff <= wb_dat_i[fsc_pkg::CTRL_EN_BIT];
      end
    end
  end

  fsc_nvme_seq u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .go_i(seq_go),
    .cmd_i(seq_cmd),
    .addr_i(seq_addr),
    .len_i(seq_len),
    .nvme_busy_i(nvme_busy_i),
    .nvme_req_o(nvme_req_o),
    .nvme_cmd_o(nvme_cmd_o),
    .nvme_addr_o(nvme_addr_o),
    .nvme_len_o(nvme_len_o),
    .done_o(seq_done)
  );

  fsc_burst_rd #(
    .BEATS(fsc_pkg::BURST_BEATS)
  ) u_burst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .go_i(burst_go),
    .level_i(tx_fifo_level_i),
    .dout_i(tx_fifo_dout_i),
    .pop_o(tx_fifo_pop_o),
    .wdata_o(nvme_wdata_o),
    .wvalid_o(nvme_wvalid_o),
    .ready_o(burst_ready)
  );

  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;
  assign cmd_busy_o = busy_ff;
  assign files_per_directory_o = fpd_ff;
  assign total_file_capacity_o = tfc_ff;
  assign current_file_size_o = fsize_ff;
  assign stored_file_count_o = fcount_ff;
  assign meta_index_o = mindex_ff;
  assign meta_dir_o = mdir_ff;
  assign meta_date_o = date_ff;
  assign meta_time_o = time_ff;
endmodule
`default_nettype wire

/* tb/fsc_ctrl_props.sv */
// Port-level checks of the command controller.
// Assumes the bind below attaches it to every controller instance.
`timescale 1ns/100ps
`default_nettype none
module fsc_ctrl_props #(
  parameter int FNUM_W = 27,
  parameter int DATE_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cmd_request_i,
  input wire logic [1:0] cmd_code_i,
  input wire logic [2:0] file_size_sel_i,
  input wire logic cmd_busy_o,
  input wire logic [2:0] current_file_size_o,
  input wire logic [FNUM_W-1:0] stored_file_count_o,
  input wire logic [15:0] tx_fifo_level_i,
  input wire logic tx_fifo_pop_o,
  input wire logic [127:0] tx_fifo_dout_i,
  input wire logic nvme_req_o,
  input wire logic [2:0] nvme_cmd_o,
  input wire logic nvme_busy_i,
  input wire logic [127:0] nvme_wdata_o,
  input wire logic nvme_wvalid_o,
  input wire logic [DATE_W-1:0] meta_date_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [5:0] run_ff;
  logic [1:0] op_ff;
  logic [2:0] sel_ff;
  logic dead_ff;
  wire logic [5:0] nxt_run = tx_fifo_pop_o ? run_ff + 6'h1 : 6'h0;
  // The opcode is taken at every idle request, so a refused one is simply overwritten.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_ff <= 6'h0;
      op_ff <= 2'h3;
      sel_ff <= 3'h0;
      dead_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      if (cmd_request_i && !cmd_busy_o) begin
        op_ff <= cmd_code_i;
        sel_ff <= file_size_sel_i;
      end
      if ($fell(cmd_busy_o) && op_ff == fsc_pkg::CMD_SHUTDOWN) begin
        dead_ff <= 1'b1;
      end
    end
  end
  busy_rise_a: assert property ($rose(cmd_busy_o) |-> $past(cmd_request_i) &&
    $past(cmd_code_i) != 2'h3) else $error("busy rose without a request");
  init_ident_a: assert property ($fell(rst_i) |-> cmd_busy_o ##[0:3]
    (nvme_req_o && nvme_cmd_o == fsc_pkg::NV_IDENTIFY)) else $error("no identify after reset");
  busy_fall_a: assert property ($fell(cmd_busy_o) |-> $past(!nvme_busy_i &&
    !tx_fifo_pop_o)) else $error("busy fell while storage still working");
  pop_run_a: assert property ($fell(tx_fifo_pop_o) |-> run_ff == 6'h20)
    else $error("pop run not 32 cycles");
  pop_level_a: assert property ($rose(tx_fifo_pop_o) |->
    $past(tx_fifo_level_i[15:5]) != 11'h0) else $error("pop without a full burst");
  beat_fwd_a: assert property (tx_fifo_pop_o |-> ##2 nvme_wvalid_o &&
    nvme_wdata_o == $past(tx_fifo_dout_i)) else $error("beat not forwarded");
  fmt_end_a: assert property ($fell(cmd_busy_o) && op_ff == fsc_pkg::CMD_FORMAT |->
    stored_file_count_o == '0 && current_file_size_o == sel_ff) else $error("bad format end");
  stamp_hold_a: assert property (cmd_busy_o && $past(cmd_busy_o) |->
    $stable(meta_date_o)) else $error("stamp changed while busy");
  dead_idle_a: assert property (dead_ff |-> !cmd_busy_o)
    else $error("command accepted after shutdown");
  ack_pulse_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) ##1 !wb_ack_o)
    else $error("bad bus acknowledge");
  cover property ($fell(cmd_busy_o) && op_ff == fsc_pkg::CMD_FORMAT);
  cover property ($fell(tx_fifo_pop_o));
  cover property (dead_ff);
endmodule
bind fsc_ctrl fsc_ctrl_props #(.FNUM_W(FNUM_W), .DATE_W(DATE_W)) u_props (.*);
`default_nettype wire

/* tb/fsc_nvme_model.sv */
// Behavioural storage controller and transmit FIFO for the controller bench.
// Assumes each request is held until busy is seen high.
`timescale 1ns/100ps
`default_nettype none
module fsc_nvme_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic fill_i,
  input wire logic req_i,
  input wire logic [2:0] cmd_i,
  input wire logic [47:0] addr_i,
  input wire logic pop_i,
  output logic busy_o,
  output logic [15:0] level_o,
  output logic [127:0] dout_o,
  output logic [15:0] cnt_o,
  output logic [2:0] cmd_o,
  output logic [47:0] addr_o
);
  logic [3:0] ph_ff;
  logic [31:0] seq_ff;
  wire logic [3:0] dly = slow_i ? 4'h3 : 4'h1;
  wire logic [3:0] last = slow_i ? 4'h9 : 4'h2;
  // Busy comes late when slow, so a controller that skips the handshake shows up.
  assign busy_o = ph_ff >= dly && ph_ff <= last;
  // A partial burst keeps bits 15..5 at zero.
  assign level_o = fill_i ? 16'h0020 : 16'h001f;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_ff <= 4'h0;
      cnt_o <= 16'h0;
      seq_ff <= 32'h0;
    end else if (ph_ff != 4'h0) begin
      ph_ff <= (ph_ff > last) ? 4'h0 : ph_ff + 4'h1;
    end else if (req_i) begin
      ph_ff <= 4'h1;
      cnt_o <= cnt_o + 16'h1;
      cmd_o <= cmd_i;
      addr_o <= addr_i;
    end
    if (pop_i) begin
      seq_ff <= seq_ff + 32'h1;
      dout_o <= {4{seq_ff}};
    end else begin
      dout_o <= ~dout_o;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_fsc_ctrl.sv */
// Self-checking bench of the command controller with a storage model behind it.
// Assumes the checker binds itself to the controller.
`timescale 1ns/100ps
`default_nettype none
module tb_fsc_ctrl;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmd_request_i, cmd_busy_o;
  logic tx_fifo_pop_o, nvme_req_o, nvme_busy_i, nvme_wvalid_o, slow, fill;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, create_date_ymd_i, create_time_hms_i, q;
  logic [31:0] meta_date_o, meta_time_o;
  logic [1:0] cmd_code_i;
  logic [2:0] file_size_sel_i, current_file_size_o, nvme_cmd_o, pcmd;
  logic [26:0] first_file_number_i, file_count_req_i, total_file_capacity_o;
  logic [26:0] stored_file_count_o, meta_index_o, meta_dir_o;
  logic [19:0] files_per_directory_o;
  logic [15:0] tx_fifo_level_i, pcnt, c0;
  logic [127:0] tx_fifo_dout_i, nvme_wdata_o;
  logic [47:0] nvme_addr_o, nvme_len_o, nvme_capacity_i, paddr;
  int error_cnt, checks_done, pops, p0;
  typedef struct packed {logic s; logic [2:0] sz; logic [31:0] d; logic [26:0] t;} fsc_row_t;
  fsc_row_t rows [2] = '{'{1'b1, 3'h1, 32'h2a0b0c0d, 27'h1ff},
    '{1'b0, 3'h0, 32'h15060708, 27'h7ff}};
  fsc_ctrl DUT (.*);
  fsc_nvme_model u_nvme (.clk_i, .rst_i, .slow_i(slow), .fill_i(fill), .req_i(nvme_req_o),
    .cmd_i(nvme_cmd_o), .addr_i(nvme_addr_o), .pop_i(tx_fifo_pop_o), .busy_o(nvme_busy_i),
    .level_o(tx_fifo_level_i), .dout_o(tx_fifo_dout_i), .cnt_o(pcnt), .cmd_o(pcmd),
    .addr_o(paddr));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (tx_fifo_pop_o === 1'b1) pops++;
  end
  task automatic summarize;
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // The master waits as long as it takes; only the watchdog ends a lost answer.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    chk("ackdrop", 1'b0, wb_ack_o);
  endtask
  // A refused request simply runs out of tries and is withdrawn.
  task automatic go(input logic [1:0] c, input logic [2:0] sz, input logic [26:0] f,
      input logic [26:0] m);
    int k;
    k = 0;
    cmd_code_i <= c;
    file_size_sel_i <= sz;
    first_file_number_i <= f;
    file_count_req_i <= m;
    cmd_request_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (cmd_busy_o !== 1'b1 && k < 8);
    cmd_request_i <= 1'b0;
  endtask
  task automatic idle;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (cmd_busy_o !== 1'b0 && k < 20000);
    chk("busy", 1'b0, cmd_busy_o);
  endtask
  initial begin
    #4000000;
    error_cnt++;
    summarize();
  end
  initial begin
    {rst_i, wb_sel_i, nvme_capacity_i} = {1'b1, 4'hf, 48'h0000_0800_0000};
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, cmd_request_i, cmd_code_i} = '0;
    {create_date_ymd_i, create_time_hms_i, file_size_sel_i} = '0;
    {first_file_number_i, file_count_req_i, slow, fill} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    idle();
    chk("fpd", 48'h4, files_per_directory_o);
    chk("ident", 48'h1, pcnt);
    chk("icmd", fsc_pkg::NV_IDENTIFY, pcmd);
    wb(1'b0, fsc_pkg::REG_CTRL, 32'h0);
    chk("ctrl", 48'h1, q);
    wb(1'b0, fsc_pkg::REG_DIR_CAP, 32'h0);
    chk("files_per_directory", 48'h4, q);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 48'h0, q);
    wb(1'b1, fsc_pkg::REG_CTRL, 32'h0);
    go(fsc_pkg::CMD_FORMAT, 3'h0, 27'h0, 27'h0);
    chk("refused", 1'b0, cmd_busy_o);
    wb(1'b1, fsc_pkg::REG_CTRL, 32'h1);
    go(2'h3, 3'h0, 27'h0, 27'h0);
    chk("code3", 1'b0, cmd_busy_o);
    @(posedge clk_i);
    foreach (rows[i]) begin
      slow <= rows[i].s;
      create_date_ymd_i <= rows[i].d;
      create_time_hms_i <= ~rows[i].d;
      c0 = pcnt;
      go(fsc_pkg::CMD_FORMAT, rows[i].sz, 27'h0, 27'h0);
      create_date_ymd_i <= 32'h0;
      idle();
      chk("total", rows[i].t, total_file_capacity_o);
      chk("size", rows[i].sz, current_file_size_o);
      chk("count", 48'h0, stored_file_count_o);
      chk("stamp", rows[i].d, meta_date_o);
      chk("tstamp", 32'(~rows[i].d), meta_time_o);
      chk("lastdir", 48'h1ff, meta_index_o);
      chk("fmtdir", 48'h1ff, meta_dir_o);
      chk("cmds", 48'd513, pcnt - c0);
      wb(1'b0, fsc_pkg::REG_TOTAL_CAP, 32'h0);
      chk("totreg", rows[i].t, q);
    end
    go(fsc_pkg::CMD_WRITE, 3'h0, 27'h0, 27'h0);
    idle();
    chk("wcount", 48'h0, stored_file_count_o);
    go(fsc_pkg::CMD_WRITE, 3'h0, 27'h3, 27'h0);
    idle();
    chk("badcount", 48'h0, stored_file_count_o);
    wb(1'b0, fsc_pkg::REG_STATUS, 32'h0);
    chk("badflag", 1'b1, q[fsc_pkg::ST_BAD_BIT]);
    p0 = pops;
    go(fsc_pkg::CMD_WRITE, 3'h0, 27'h0, 27'h1);
    repeat (40) @(posedge clk_i);
    chk("nopop", p0, pops);
    chk("wcmd", fsc_pkg::NV_WRITE, pcmd);
    chk("waddr", fsc_pkg::DATA_LBA, paddr);
    chk("wlen", 48'h10000, nvme_len_o);
    chk("windex", 48'h0, meta_index_o);
    chk("wdir", 48'h0, meta_dir_o);
    fill <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk("pops", 1'b1, pops - p0 >= 64);
    chk("wbusy", 1'b1, cmd_busy_o);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    idle();
    chk("reident", 48'h1, pcnt);
    go(fsc_pkg::CMD_SHUTDOWN, 3'h0, 27'h0, 27'h0);
    idle();
    chk("scmd", fsc_pkg::NV_SHUTDOWN, pcmd);
    wb(1'b0, fsc_pkg::REG_STATUS, 32'h0);
    chk("dead", 1'b1, q[fsc_pkg::ST_DEAD_BIT]);
    go(fsc_pkg::CMD_FORMAT, 3'h0, 27'h0, 27'h0);
    chk("after", 1'b0, cmd_busy_o);
    summarize();
  end
endmodule
`default_nettype wire
